// ### aat_pkg.sv
// Shared constants for the accumulator arithmetic and transfer executor
package aat_pkg;

    // ********************************************************
    // Register map (byte offsets on the Wishbone bus)
    // ********************************************************
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_SP = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OPND_LSB = 8;
    localparam int FLAG_Z = 0;
    localparam int FLAG_C = 1;
    localparam int FLAG_AC = 2;
    localparam int FLAG_OV = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_BAD_OP = 1;

    // ********************************************************
    // Reset values and constants
    // ********************************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] SP_RST = 8'h00;
    localparam logic [7:0] SP_STEP = 8'h02;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // Program address where interrupt service code starts
    localparam logic [7:0] ISR_ENTRY = 8'h10;

    // ********************************************************
    // Instruction codes
    // ********************************************************
    typedef enum logic [4:0] {
        OP_ST_IND  = 5'b00000,
        OP_XCH     = 5'b00001,
        OP_PUSH    = 5'b00010,
        OP_POP     = 5'b00011,
        OP_ADD_AI  = 5'b00100,
        OP_ADD_AM  = 5'b00101,
        OP_ADD_MA  = 5'b00110,
        OP_ADDC_AM = 5'b00111,
        OP_ADDC_MA = 5'b01000,
        OP_ADDC_A  = 5'b01001,
        OP_ADDC_M  = 5'b01010,
        OP_SUB_AI  = 5'b01011,
        OP_SUB_AM  = 5'b01100,
        OP_SUB_MA  = 5'b01101,
        OP_SUBC_AM = 5'b01110,
        OP_SUBC_MA = 5'b01111,
        OP_SUBC_A  = 5'b10000,
        OP_SUBC_M  = 5'b10001,
        OP_INC_M   = 5'b10010,
        OP_DEC_M   = 5'b10011,
        OP_CLR_M   = 5'b10100
    } aat_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RD   = 3'b001,
        S_POP  = 3'b010,
        S_EXEC = 3'b011,
        S_PUSH = 3'b100
    } aat_state_t;

endpackage

// ### aat_alu_if.sv
// Operand and result bundle between the executor and its adder
`timescale 1ns/1ps
interface aat_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic sub;
    logic [7:0] res;
    logic z;
    logic c;
    logic ac;
    logic ov;
    modport calc(input a, input b, input cin, input sub,
                 output res, output z, output c, output ac, output ov);
    modport user(output a, output b, output cin, output sub,
                 input res, input z, input c, input ac, input ov);
endinterface

// ### aat_alu.sv
// Eight-bit adder/subtractor with zero, carry, half-carry and overflow
`timescale 1ns/1ps
module aat_alu (
    // Operands in, result and flags out
    aat_alu_if.calc alu
);
    logic [7:0] b_eff;
    logic cin_eff;
    logic [4:0] lo_sum;
    logic [8:0] full_sum;

    // Subtraction is addition of the two's complement
    assign b_eff = alu.sub ? ~alu.b : alu.b;
    // For subtraction cin is a borrow, so the incoming one is inverted
    assign cin_eff = alu.sub ? ~alu.cin : alu.cin;
    assign lo_sum = {1'b0, alu.a[3:0]} + {1'b0, b_eff[3:0]} +
                    {4'h0, cin_eff};
    assign full_sum = {1'b0, alu.a} + {1'b0, b_eff} + {8'h00, cin_eff};
    assign alu.res = full_sum[7:0];
    assign alu.z = (full_sum[7:0] == 8'h00);
    assign alu.c = alu.sub ? ~full_sum[8] : full_sum[8];
    assign alu.ac = alu.sub ? ~lo_sum[4] : lo_sum[4];
    // Signed overflow: like-signed inputs giving an unlike-signed sum
    assign alu.ov = (alu.a[7] == b_eff[7]) &&
                    (full_sum[7] != alu.a[7]);
endmodule

// ### aat_exec.sv
// Accumulator arithmetic and transfer executor with Wishbone registers
//
// Overview of operation
// - Indirect store writes accumulator to byte addressed by memory pointer, 2T.
// - Swap exchanges accumulator and memory byte, flags untouched.
// - Context save writes flags and accumulator at stack, pointer plus two.
// - Context restore drops pointer by two, reloads accumulator and flags.
// - Interrupt code at 0x10 saves context first, restores before return.
// - Add immediate to accumulator, update four flags.
// - Add memory and accumulator into accumulator or memory, four flags.
// - Add with carry of memory and accumulator, destination by form.
// - Add carry alone to accumulator or memory byte in place.
// - Subtract immediate or memory from accumulator via two's complement.
// - Subtract accumulator from memory byte, result back to memory.
// - Subtract memory and carry from accumulator into accumulator.
// - Subtract accumulator and carry from memory into memory.
// - Subtract carry alone from accumulator or memory byte in place.
// - Increment memory byte, update four flags.
// - Decrement memory byte, flags as for subtraction.
// - Clear memory byte to zero, flags untouched.
// - Half-carry set on carry out of low nibble, or on borrow into it when subtracting.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module aat_exec import aat_pkg::*; (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Data memory port, read data valid the cycle after mem_re_o
    output logic [7:0] mem_addr_o,
    output logic mem_re_o,
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    // Status
    output logic busy_o
);

    // ********************************************************
    // Decode helpers
    // ********************************************************
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] off);
        reg_hit = (adr[7:2] == off[7:2]);
    endfunction

    function automatic logic needs_read(input aat_op_t op);
        needs_read = !(op inside {OP_PUSH, OP_POP, OP_ADD_AI, OP_ADDC_A,
                                  OP_SUB_AI, OP_SUBC_A, OP_CLR_M});
    endfunction

    function automatic logic writes_mem(input aat_op_t op);
        writes_mem = op inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M,
                                OP_SUB_MA, OP_SUBC_MA, OP_SUBC_M,
                                OP_INC_M, OP_DEC_M};
    endfunction

    // ********************************************************
    // State
    // ********************************************************
    aat_state_t state_ff, nxt_state;
    aat_op_t op_ff, nxt_op;
    logic [7:0] opnd_ff, nxt_opnd;
    logic [7:0] acc_ff, nxt_acc;
    logic [3:0] flags_ff, nxt_flags;
    logic [7:0] sp_ff, nxt_sp;
    logic bad_op_ff, nxt_bad_op;
    logic [7:0] mem_addr_ff, nxt_mem_addr;
    logic [7:0] mem_wdata_ff, nxt_mem_wdata;
    logic mem_re_ff, nxt_mem_re;
    logic mem_we_ff, nxt_mem_we;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic busy;
    logic req;
    logic wr;
    logic start;
    logic [4:0] cmd_code;

    aat_alu_if alu_bus();

    aat_alu u_alu (
        .alu(alu_bus)
    );

    // ********************************************************
    // Bus decode
    // ********************************************************
    // The write still in flight counts as busy so the next command
    // cannot read a byte that is about to change
    assign busy = (state_ff != S_IDLE) || mem_we_ff;
    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req && wb_we_i;
    assign cmd_code = wb_dat_i[CMD_OP_LSB +: 5];
    assign start = wr && reg_hit(wb_adr_i, REG_CMD) && wb_sel_i[0] &&
                   !busy;

    // ********************************************************
    // Adder operand selection
    // ********************************************************
    always_comb begin
        alu_bus.a = acc_ff;
        alu_bus.b = mem_rdata_i;
        alu_bus.cin = 1'b0;
        alu_bus.sub = 1'b0;
        unique case (op_ff)
            OP_ADD_AI: begin
                alu_bus.b = opnd_ff;
            end
            OP_ADDC_AM, OP_ADDC_MA: begin
                alu_bus.cin = flags_ff[FLAG_C];
            end
            OP_ADDC_A: begin
                alu_bus.b = BYTE_ZERO;
                alu_bus.cin = flags_ff[FLAG_C];
            end
            OP_ADDC_M: begin
                alu_bus.a = mem_rdata_i;
                alu_bus.b = BYTE_ZERO;
                alu_bus.cin = flags_ff[FLAG_C];
            end
            OP_SUB_AI: begin
                alu_bus.b = opnd_ff;
                alu_bus.sub = 1'b1;
            end
            OP_SUB_AM: begin
                alu_bus.sub = 1'b1;
            end
            OP_SUB_MA: begin
                alu_bus.a = mem_rdata_i;
                alu_bus.b = acc_ff;
                alu_bus.sub = 1'b1;
            end
            OP_SUBC_AM: begin
                alu_bus.cin = flags_ff[FLAG_C];
                alu_bus.sub = 1'b1;
            end
            OP_SUBC_MA: begin
                alu_bus.a = mem_rdata_i;
                alu_bus.b = acc_ff;
                alu_bus.cin = flags_ff[FLAG_C];
                alu_bus.sub = 1'b1;
            end
            OP_SUBC_A: begin
                alu_bus.b = BYTE_ZERO;
                alu_bus.cin = flags_ff[FLAG_C];
                alu_bus.sub = 1'b1;
            end
            OP_SUBC_M: begin
                alu_bus.a = mem_rdata_i;
                alu_bus.b = BYTE_ZERO;
                alu_bus.cin = flags_ff[FLAG_C];
                alu_bus.sub = 1'b1;
            end
            OP_INC_M: begin
                alu_bus.a = mem_rdata_i;
                alu_bus.b = BYTE_ONE;
            end
            OP_DEC_M: begin
                alu_bus.a = mem_rdata_i;
                alu_bus.b = BYTE_ONE;
                alu_bus.sub = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ********************************************************
    // Sequencer and datapath next values
    // ********************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_opnd = opnd_ff;
        nxt_acc = acc_ff;
        nxt_flags = flags_ff;
        nxt_sp = sp_ff;
        nxt_bad_op = bad_op_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_mem_re = 1'b0;
        nxt_mem_we = 1'b0;
        unique case (state_ff)
            S_IDLE: begin
                // Software writes to the core registers only while idle
                if (wr && !busy && wb_sel_i[0]) begin
                    if (reg_hit(wb_adr_i, REG_ACC)) begin
                        nxt_acc = wb_dat_i[7:0];
                    end
                    if (reg_hit(wb_adr_i, REG_FLAGS)) begin
                        nxt_flags = wb_dat_i[3:0];
                    end
                    if (reg_hit(wb_adr_i, REG_SP)) begin
                        nxt_sp = wb_dat_i[7:0];
                    end
                end
                if (start && cmd_code > OP_CLR_M) begin
                    nxt_bad_op = 1'b1;
                end else if (start) begin
                    nxt_bad_op = 1'b0;
                    nxt_op = aat_op_t'(cmd_code);
                    if (wb_sel_i[1]) begin
                        nxt_opnd = wb_dat_i[CMD_OPND_LSB +: 8];
                    end
                    if (aat_op_t'(cmd_code) == OP_PUSH) begin
                        // Accumulator goes to the lower byte of the pair
                        nxt_mem_we = 1'b1;
                        nxt_mem_addr = sp_ff;
                        nxt_mem_wdata = acc_ff;
                        nxt_state = S_PUSH;
                    end else if (aat_op_t'(cmd_code) == OP_POP) begin
                        nxt_mem_re = 1'b1;
                        nxt_mem_addr = sp_ff - SP_STEP;
                        nxt_state = S_RD;
                    end else if (needs_read(aat_op_t'(cmd_code))) begin
                        nxt_mem_re = 1'b1;
                        // Pointer high byte is never fetched
                        nxt_mem_addr = wb_sel_i[1] ?
                            wb_dat_i[CMD_OPND_LSB +: 8] : opnd_ff;
                        nxt_state = S_RD;
                    end else begin
                        nxt_state = S_EXEC;
                    end
                end
            end
            S_RD: begin
                if (op_ff == OP_POP) begin
                    // Second read is pipelined behind the first
                    nxt_mem_re = 1'b1;
                    nxt_mem_addr = sp_ff - BYTE_ONE;
                    nxt_sp = sp_ff - SP_STEP;
                    nxt_state = S_POP;
                end else begin
                    nxt_state = S_EXEC;
                end
            end
            S_POP: begin
                nxt_acc = mem_rdata_i;
                nxt_state = S_EXEC;
            end
            S_PUSH: begin
                // Saving and restoring in strict pairs keeps nested
                // service code balanced on the stack
                nxt_mem_we = 1'b1;
                nxt_mem_addr = sp_ff + BYTE_ONE;
                nxt_mem_wdata = {4'h0, flags_ff};
                nxt_sp = sp_ff + SP_STEP;
                nxt_state = S_IDLE;
            end
            S_EXEC: begin
                nxt_state = S_IDLE;
                unique case (op_ff)
                    OP_ST_IND: begin
                        // Read data is the pointer low byte
                        nxt_mem_we = 1'b1;
                        nxt_mem_addr = mem_rdata_i;
                        nxt_mem_wdata = acc_ff;
                    end
                    OP_XCH: begin
                        nxt_acc = mem_rdata_i;
                        nxt_mem_we = 1'b1;
                        nxt_mem_addr = opnd_ff;
                        nxt_mem_wdata = acc_ff;
                    end
                    OP_POP: begin
                        nxt_flags = mem_rdata_i[3:0];
                    end
                    OP_CLR_M: begin
                        nxt_mem_we = 1'b1;
                        nxt_mem_addr = opnd_ff;
                        nxt_mem_wdata = BYTE_ZERO;
                    end
                    default: begin
                        nxt_flags[FLAG_Z] = alu_bus.z;
                        nxt_flags[FLAG_C] = alu_bus.c;
                        nxt_flags[FLAG_AC] = alu_bus.ac;
                        nxt_flags[FLAG_OV] = alu_bus.ov;
                        if (writes_mem(op_ff)) begin
                            nxt_mem_we = 1'b1;
                            nxt_mem_addr = opnd_ff;
                            nxt_mem_wdata = alu_bus.res;
                        end else begin
                            nxt_acc = alu_bus.res;
                        end
                    end
                endcase
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // ********************************************************
    // Sequencer registers
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= S_IDLE;
            op_ff <= OP_ST_IND;
            opnd_ff <= BYTE_ZERO;
            bad_op_ff <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            opnd_ff <= nxt_opnd;
            bad_op_ff <= nxt_bad_op;
        end
    end

    // ********************************************************
    // Accumulator, flags and stack pointer
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= ACC_RST;
            flags_ff <= FLAGS_RST;
            sp_ff <= SP_RST;
        end else if (ce_i) begin
            acc_ff <= nxt_acc;
            flags_ff <= nxt_flags;
            sp_ff <= nxt_sp;
        end
    end

    // ********************************************************
    // Memory port
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_ff <= BYTE_ZERO;
            mem_wdata_ff <= BYTE_ZERO;
            mem_re_ff <= 1'b0;
            mem_we_ff <= 1'b0;
        end else if (ce_i) begin
            mem_addr_ff <= nxt_mem_addr;
            mem_wdata_ff <= nxt_mem_wdata;
            mem_re_ff <= nxt_mem_re;
            mem_we_ff <= nxt_mem_we;
        end
    end

    // ********************************************************
    // Wishbone answer
    // ********************************************************
    // Unmapped offsets still get an ack and read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= WORD_ZERO;
        end else if (ce_i) begin
            ack_ff <= req;
            if (req && !wb_we_i) begin
                dat_ff <= WORD_ZERO;
                if (reg_hit(wb_adr_i, REG_CMD)) begin
                    dat_ff[CMD_OP_LSB +: 5] <= op_ff;
                    dat_ff[CMD_OPND_LSB +: 8] <= opnd_ff;
                end
                if (reg_hit(wb_adr_i, REG_ACC)) begin
                    dat_ff[7:0] <= acc_ff;
                end
                if (reg_hit(wb_adr_i, REG_FLAGS)) begin
                    dat_ff[3:0] <= flags_ff;
                end
                if (reg_hit(wb_adr_i, REG_SP)) begin
                    dat_ff[7:0] <= sp_ff;
                end
                if (reg_hit(wb_adr_i, REG_STATUS)) begin
                    dat_ff[STAT_BUSY] <= busy;
                    dat_ff[STAT_BAD_OP] <= bad_op_ff;
                end
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign mem_addr_o = mem_addr_ff;
    assign mem_wdata_o = mem_wdata_ff;
    assign mem_re_o = mem_re_ff;
    assign mem_we_o = mem_we_ff;
    assign busy_o = busy;

endmodule

// ### aat_exec_props.sv
// Protocol and sequencing assertions for the executor
`timescale 1ns/1ps
module aat_exec_props import aat_pkg::*; (
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Memory and status
    input wire logic [7:0] mem_addr_o,
    input wire logic mem_re_o,
    input wire logic mem_we_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic busy_o
);
    // ****************************************
    // Request decode and properties
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req, cmd;
    logic [4:0] op;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    // Commands sent while busy are dropped, so they start nothing
    assign cmd = req && wb_we_i && wb_adr_i == REG_CMD && wb_sel_i[0] &&
                 !busy_o;
    assign op = wb_dat_i[4:0];
    a_ack_latency: assert property (req |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_busy_starts: assert property (cmd && op <= 5'h14 |=> busy_o)
        else $error("legal command did not raise busy");
    a_idle_quiet: assert property (!busy_o |-> !mem_re_o && !mem_we_o)
        else $error("memory strobe while idle");
    a_busy_bounded: assert property ($rose(busy_o) |-> ##[1:8] !busy_o)
        else $error("command did not finish");
    a_store_ptr: assert property (cmd && op == 5'h00 |->
        ##[1:3] mem_re_o ##2 mem_we_o)
        else $error("indirect store sequence wrong");
    a_push_pair: assert property (cmd && op == 5'h02 |-> ##1 mem_we_o
        ##1 (mem_we_o && mem_addr_o == $past(mem_addr_o) + 8'h01))
        else $error("context save pair wrong");
    a_pop_pair: assert property (cmd && op == 5'h03 |-> ##1 mem_re_o
        ##1 (mem_re_o && mem_addr_o == $past(mem_addr_o) + 8'h01))
        else $error("context restore pair wrong");
    a_clear_zero: assert property (cmd && op == 5'h14 |->
        ##[1:4] (mem_we_o && mem_wdata_o == 8'h00))
        else $error("clear did not write zero");
    c_push: cover property (cmd && op == 5'h02);
    c_pop: cover property (cmd && op == 5'h03);
    c_mem_arith: cover property (cmd && op == 5'h06);
endmodule
bind aat_exec aat_exec_props aat_exec_props_inst (.clk_i, .rst_i, .ce_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .mem_addr_o, .mem_re_o, .mem_we_o, .mem_wdata_o,
    .mem_rdata_i, .busy_o);

// ### aat_mem_model.sv
// Synchronous data memory on the far side of the executor
`timescale 1ns/1ps
module aat_mem_model (
    // Clock and memory port
    input wire logic clk_i,
    input wire logic [7:0] mem_addr_i,
    input wire logic mem_re_i,
    input wire logic mem_we_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [256];
    initial mem_rdata_o = 8'h00;
    // Read data is good only in the cycle after the strobe; it toggles
    // elsewhere so a late sample never finds a plausible stale byte
    always @(posedge clk_i) begin
        if (mem_we_i)
            mem[mem_addr_i] <= mem_wdata_i;
        if (mem_re_i)
            mem_rdata_o <= mem[mem_addr_i];
        else
            mem_rdata_o <= ~mem_rdata_o;
    end
endmodule

// ### aat_exec_tb.sv
// Self-checking bench for the arithmetic and transfer executor
`timescale 1ns/1ps
module aat_exec_tb;
    import aat_pkg::*;
    // ****************************************
    // Signals, instances and helpers
    // ****************************************
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic mem_re_o, mem_we_o, busy_o;
    logic [7:0] wb_adr_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    int fails, total_checks;
    wire logic [7:0] m40 = aat_mem_model_inst.mem[8'h40];
    aat_exec aat_exec_inst (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .mem_addr_o, .mem_re_o, .mem_we_o, .mem_wdata_o, .mem_rdata_i,
        .busy_o);
    aat_mem_model aat_mem_model_inst (.clk_i, .mem_addr_i(mem_addr_o),
        .mem_re_i(mem_re_o), .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o),
        .mem_rdata_o(mem_rdata_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic results;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] q);
        int n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        check(wb_ack_o, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb(1'b1, adr, dat, q);
    endtask
    task automatic rd(input logic [7:0] adr, output logic [31:0] q);
        wb(1'b0, adr, 32'h0000_0000, q);
    endtask
    task automatic run(input logic [4:0] op, input logic [7:0] opnd);
        logic [31:0] q;
        int n = 0;
        wr(REG_CMD, {16'h0000, opnd, 3'b000, op});
        do begin
            rd(REG_STATUS, q);
            n++;
        end while (q[STAT_BUSY] !== 1'b0 && n < 20);
        check(q[STAT_BUSY], 1'b0);
    endtask
    task automatic setr(input logic [7:0] acc, input logic [3:0] fl);
        wr(REG_ACC, 32'(acc));
        wr(REG_FLAGS, 32'(fl));
    endtask
    task automatic chkr(input logic [7:0] acc, input logic [3:0] fl);
        logic [31:0] q;
        rd(REG_ACC, q);
        check(q, 32'(acc));
        rd(REG_FLAGS, q);
        check(q, 32'(fl));
    endtask
    // Expected {ov, ac, c, z, result}; borrow flags are inverted carries
    function automatic logic [11:0] calc(input logic [7:0] x, y,
                                         input logic ci, sb);
        logic [7:0] ye;
        logic [8:0] r;
        logic [4:0] h;
        ye = sb ? ~y : y;
        r = x + ye + (ci ^ sb);
        h = x[3:0] + ye[3:0] + (ci ^ sb);
        return {x[7] == ye[7] && r[7] != x[7], h[4] ^ sb, r[8] ^ sb,
                r[7:0] == 8'h00, r[7:0]};
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_arith(input logic [7:0] a, m, input logic cf);
        logic [11:0] e;
        logic [7:0] y;
        logic dm;
        for (int op = 4; op <= 19; op++) begin
            dm = op inside {6, 8, 10, 13, 15, 17, 18, 19};
            y = dm ? a : m;
            if (op inside {4, 11})
                y = 8'h3C;
            if (op inside {9, 10, 16, 17})
                y = 8'h00;
            if (op >= 18)
                y = 8'h01;
            e = calc(dm ? m : a, y, cf && op inside {[7:10], [14:17]},
                     op inside {[11:17], 19});
            aat_mem_model_inst.mem[8'h40] = m;
            setr(a, {2'b00, cf, 1'b0});
            run(5'(op), op inside {4, 11} ? 8'h3C : 8'h40);
            chkr(dm ? a : e[7:0], e[11:8]);
            check(m40, dm ? e[7:0] : m);
        end
    endtask
    task automatic t_xfer;
        logic [31:0] q;
        aat_mem_model_inst.mem[8'h1E] = 8'h5B;
        aat_mem_model_inst.mem[8'h1F] = 8'h00;
        setr(8'hA5, 4'h9);
        run(OP_ST_IND, 8'h1E);
        check(aat_mem_model_inst.mem[8'h5B], 8'hA5);
        chkr(8'hA5, 4'h9);
        aat_mem_model_inst.mem[8'h30] = 8'h3C;
        run(OP_XCH, 8'h30);
        check(aat_mem_model_inst.mem[8'h30], 8'hA5);
        chkr(8'h3C, 4'h9);
        run(OP_CLR_M, 8'h30);
        check(aat_mem_model_inst.mem[8'h30], 8'h00);
        chkr(8'h3C, 4'h9);
        wr(REG_SP, 32'h0000_0020);
        run(OP_PUSH, 8'h00);
        check(aat_mem_model_inst.mem[8'h20], 8'h3C);
        check(aat_mem_model_inst.mem[8'h21], 8'h09);
        rd(REG_SP, q);
        check(q, 32'h0000_0022);
        setr(8'h00, 4'h6);
        run(OP_POP, 8'h00);
        rd(REG_SP, q);
        check(q, 32'h0000_0020);
        chkr(8'h3C, 4'h9);
        wr(REG_CMD, 32'h0000_0015);
        rd(REG_STATUS, q);
        check(q[STAT_BAD_OP], 1'b1);
        wr(8'h14, 32'h0000_00FF);
        rd(8'h14, q);
        check(q, 32'h0000_0000);
        chkr(8'h3C, 4'h9);
    endtask
    initial begin
        fails = 0;
        total_checks = 0;
        rst_i <= 1'b1;
        ce_i <= 1'b1;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_adr_i <= 8'h00;
        wb_sel_i <= 4'hF;
        wb_dat_i <= 32'h0000_0000;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chkr(8'h00, 4'h0);
        t_arith(8'h7F, 8'h01, 1'b1);
        t_arith(8'h00, 8'h80, 1'b0);
        t_arith(8'hC4, 8'hFF, 1'b1);
        t_xfer;
        results;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        results;
    end
endmodule
